// [verilog/scb_defines.vh]
/*
 * Constants for the serial block's UART setup and interrupt logic:
 * register offsets, field positions, reset values and mode codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SCB_DEFINES_VH
`define SCB_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SCB_OFF_CTRL        12'h000
`define SCB_OFF_UART_CTRL   12'h040
`define SCB_OFF_TX_CTRL     12'h200
`define SCB_OFF_TXQ_CTRL    12'h204
`define SCB_OFF_RX_CTRL     12'h300
`define SCB_OFF_RXQ_CTRL    12'h304
`define SCB_OFF_TX_IRQ      12'h400
`define SCB_OFF_TX_MASK     12'h404
`define SCB_OFF_RX_IRQ      12'h408
`define SCB_OFF_RX_MASK     12'h40C
`define SCB_OFF_STATUS      12'h410
`define SCB_OFF_TX_DATA     12'h500
`define SCB_OFF_RX_DATA     12'h504

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCB_ENABLE_BIT      31
`define SCB_MODE_HI         25
`define SCB_MODE_LO         24
`define SCB_LOOP_BIT        16
`define SCB_WIDTH_HI        3
`define SCB_MSB_BIT         8
`define SCB_MEDIAN_BIT      9
`define SCB_TRIG_HI         2
`define SCB_CLEAR_BIT       16
`define SCB_FREEZE_BIT      17

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define SCB_PROTO_UART      2'h2
`define SCB_SUB_STD         2'h0
`define SCB_SUB_CARD        2'h1
`define SCB_SUB_IR          2'h2
`define SCB_WIDTH_RST       4'h7
`define SCB_WORD_ZERO       32'h0000_0000
`define SCB_TX_EVENTS       8
`define SCB_RX_EVENTS       9

`endif

// [verilog/scb_uart_setup.v]
/*
 * UART setup, enable/reinit and interrupt aggregation of the serial
 * block, with a small TX and RX FIFO and an APB register slave.
 * Assumes one clock ref_clk, async active-high rst, and that the
 * bit engine sits outside and talks over the eng_* ports.
 */
`include "scb_defines.vh"

module scb_uart_setup #(
   parameter DEPTH_LOG = 3,
   parameter DW        = 16
) (
   input  wire          ref_clk,
   input  wire          rst,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   input  wire          rx_line,
   output reg           tx_line,
   input  wire          eng_tx_bit,
   output reg  [DW-1:0] eng_tx_word,
   output reg           eng_tx_valid,
   input  wire          eng_tx_pop,
   input  wire [DW-1:0] eng_rx_word,
   input  wire          eng_rx_push,
   output reg           eng_rx_bit,
   output reg           uart_active,
   output reg  [1:0]    sub_mode,
   output reg  [3:0]    frame_bits_m1,
   output reg           tx_msb_first,
   output reg           rx_msb_first,
   output reg           tx_run,
   output reg           rx_run,
   output reg           shift_clear_tx,
   output reg           shift_clear_rx,
   input  wire          ev_nack,
   input  wire          ev_tx_done,
   input  wire          ev_arb_lost,
   input  wire          ev_frame_err,
   input  wire          ev_parity_err,
   input  wire          ev_lin_baud,
   input  wire          ev_lin_break,
   output reg           irq_tx,
   output reg           irq_rx
);

   localparam DEPTH = 1 << DEPTH_LOG;
   localparam TXN   = `SCB_TX_EVENTS;
   localparam RXN   = `SCB_RX_EVENTS;

   // ----------------------------------------------------------------
   // software-visible control registers
   // ----------------------------------------------------------------
   reg [31:0]    ctrl_q;
   reg [31:0]    uctrl_q;
   reg [31:0]    txc_q;
   reg [31:0]    rxc_q;
   reg [31:0]    txq_q;
   reg [31:0]    rxq_q;
   reg [TXN-1:0] tx_flag_q;
   reg [TXN-1:0] tx_mask_q;
   reg [RXN-1:0] rx_flag_q;
   reg [RXN-1:0] rx_mask_q;
   // shadow copies, loaded only on the enable rising edge; enable_d1_q follows the enable every cycle
   reg [1:0]     sub_q;
   reg           loop_q;
   reg           median_q;
   reg           enable_d1_q;

   wire blk_on   = ctrl_q[`SCB_ENABLE_BIT];
   wire proto_ok = ctrl_q[`SCB_MODE_HI:`SCB_MODE_LO]
                   == `SCB_PROTO_UART;
   wire active   = blk_on & proto_ok;
   wire reinit   = blk_on & ~enable_d1_q;

   wire acc      = psel & penable & pready;
   wire wr       = acc & pwrite;
   wire rd       = acc & ~pwrite;

   // ----------------------------------------------------------------
   // fifos
   // ----------------------------------------------------------------
   reg [DW-1:0]      txm [0:DEPTH-1];
   reg [DW-1:0]      rxm [0:DEPTH-1];
   // one extra pointer bit tells full from empty
   reg [DEPTH_LOG:0] tx_wp_q;
   reg [DEPTH_LOG:0] tx_rp_q;
   reg [DEPTH_LOG:0] rx_wp_q;
   reg [DEPTH_LOG:0] rx_rp_q;
   wire [DEPTH_LOG:0] tx_cnt = tx_wp_q - tx_rp_q;
   wire [DEPTH_LOG:0] rx_cnt = rx_wp_q - rx_rp_q;
   wire tx_full  = tx_cnt == DEPTH;
   wire tx_empty = tx_cnt == 0;
   wire rx_full  = rx_cnt == DEPTH;
   wire rx_empty = rx_cnt == 0;

   wire tx_clr = txq_q[`SCB_CLEAR_BIT] | reinit | ~active;
   wire rx_clr = rxq_q[`SCB_CLEAR_BIT] | reinit | ~active;
   wire tx_frz = txq_q[`SCB_FREEZE_BIT];
   wire rx_frz = rxq_q[`SCB_FREEZE_BIT];
   wire tx_en  = active & txc_q[`SCB_ENABLE_BIT];
   wire rx_en  = active & rxc_q[`SCB_ENABLE_BIT];

   wire sw_push = wr & (paddr == `SCB_OFF_TX_DATA);
   wire sw_pop  = rd & (paddr == `SCB_OFF_RX_DATA);
   // freeze holds the pointers still for hardware-side access only
   wire hw_pop  = eng_tx_pop & tx_en & ~tx_frz;
   wire hw_push = eng_rx_push & rx_en & ~rx_frz;

   wire tx_wr_ok = sw_push & ~tx_full;
   wire tx_rd_ok = hw_pop & ~tx_empty;
   wire rx_wr_ok = hw_push & ~rx_full;
   wire rx_rd_ok = sw_pop & ~rx_empty;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_wp_q <= {(DEPTH_LOG+1){1'b0}};
         tx_rp_q <= {(DEPTH_LOG+1){1'b0}};
         rx_wp_q <= {(DEPTH_LOG+1){1'b0}};
         rx_rp_q <= {(DEPTH_LOG+1){1'b0}};
      end else begin
         if (tx_clr) begin
            tx_wp_q <= {(DEPTH_LOG+1){1'b0}};
            tx_rp_q <= {(DEPTH_LOG+1){1'b0}};
         end else begin
            if (tx_wr_ok)
               tx_wp_q <= tx_wp_q + 1'b1;
            if (tx_rd_ok)
               tx_rp_q <= tx_rp_q + 1'b1;
         end
         if (rx_clr) begin
            rx_wp_q <= {(DEPTH_LOG+1){1'b0}};
            rx_rp_q <= {(DEPTH_LOG+1){1'b0}};
         end else begin
            if (rx_wr_ok)
               rx_wp_q <= rx_wp_q + 1'b1;
            if (rx_rd_ok)
               rx_rp_q <= rx_rp_q + 1'b1;
         end
      end
   end

   // memories carry no reset; pointers make stale words invisible
   always @(posedge ref_clk) begin
      if (tx_wr_ok & ~tx_clr)
         txm[tx_wp_q[DEPTH_LOG-1:0]] <= pwdata[DW-1:0];
      if (rx_wr_ok & ~rx_clr)
         rxm[rx_wp_q[DEPTH_LOG-1:0]] <= eng_rx_word;
   end

   // ----------------------------------------------------------------
   // event sources and sticky flags
   // ----------------------------------------------------------------
   // trigger field is three bits; a fourth keeps the compare unsigned
   // against a count that may reach the full depth
   wire [3:0] tx_trig = {1'b0, txq_q[`SCB_TRIG_HI:0]};
   wire [3:0] rx_trig = {1'b0, rxq_q[`SCB_TRIG_HI:0]};
   wire card = sub_q == `SCB_SUB_CARD;

   wire [TXN-1:0] tx_ev = {
      ev_arb_lost & tx_en,
      ev_tx_done & tx_en,
      ev_nack & card & tx_en,
      hw_pop & tx_empty,
      sw_push & tx_full,
      tx_en & tx_empty,
      tx_en & ~tx_full,
      tx_en & (tx_cnt < tx_trig)};

   wire [RXN-1:0] rx_ev = {
      ev_lin_break & rx_en,
      ev_lin_baud & rx_en,
      ev_parity_err & rx_en,
      ev_frame_err & rx_en,
      sw_pop & rx_empty,
      hw_push & rx_full,
      rx_en & ~rx_empty,
      rx_en & rx_full,
      rx_en & (rx_cnt > rx_trig)};

   // write-one-to-clear; a new event in the same cycle wins
   wire [TXN-1:0] tx_w1c = (wr & (paddr == `SCB_OFF_TX_IRQ)) ?
                           pwdata[TXN-1:0] : {TXN{1'b0}};
   wire [RXN-1:0] rx_w1c = (wr & (paddr == `SCB_OFF_RX_IRQ)) ?
                           pwdata[RXN-1:0] : {RXN{1'b0}};

   // ----------------------------------------------------------------
   // median filter, loop back, pin synchroniser
   // ----------------------------------------------------------------
   reg  [2:0] rx_sync_q;
   reg  [2:0] med_q;
   reg        rx_clean_q;
   wire       rx_changed = rx_sync_q[2] ^ rx_clean_q;
   wire       rx_src = loop_q ? eng_tx_bit : rx_clean_q;
   wire       med_out = (med_q[0] & med_q[1]) | (med_q[1] & med_q[2])
                        | (med_q[0] & med_q[2]);

   // ----------------------------------------------------------------
   // register bus and state
   // ----------------------------------------------------------------
   reg [31:0] rdata;
   reg        hit;
   always @* begin
      hit   = 1'b1;
      rdata = `SCB_WORD_ZERO;
      case (paddr)
         `SCB_OFF_CTRL:      rdata = ctrl_q;
         `SCB_OFF_UART_CTRL: rdata = uctrl_q;
         `SCB_OFF_TX_CTRL:   rdata = txc_q;
         `SCB_OFF_RX_CTRL:   rdata = rxc_q;
         `SCB_OFF_TXQ_CTRL:  rdata = txq_q;
         `SCB_OFF_RXQ_CTRL:  rdata = rxq_q;
         `SCB_OFF_TX_IRQ:    rdata = {{(32-TXN){1'b0}}, tx_flag_q};
         `SCB_OFF_TX_MASK:   rdata = {{(32-TXN){1'b0}}, tx_mask_q};
         `SCB_OFF_RX_IRQ:    rdata = {{(32-RXN){1'b0}}, rx_flag_q};
         `SCB_OFF_RX_MASK:   rdata = {{(32-RXN){1'b0}}, rx_mask_q};
         `SCB_OFF_STATUS:    rdata = {14'h0000, rx_cnt[DEPTH_LOG:0],
                                      {(12-DEPTH_LOG){1'b0}},
                                      tx_cnt[DEPTH_LOG:0], active};
         `SCB_OFF_TX_DATA:   rdata = `SCB_WORD_ZERO;
         `SCB_OFF_RX_DATA:   rdata = rx_empty ? `SCB_WORD_ZERO :
            {{(32-DW){1'b0}}, rxm[rx_rp_q[DEPTH_LOG-1:0]]};
         default:            hit = 1'b0;
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `SCB_WORD_ZERO;
         uctrl_q <= `SCB_WORD_ZERO;
         txc_q <= {28'h0000000, `SCB_WIDTH_RST};
         rxc_q <= {28'h0000000, `SCB_WIDTH_RST};
         txq_q <= `SCB_WORD_ZERO;
         rxq_q <= `SCB_WORD_ZERO;
         tx_flag_q <= {TXN{1'b0}};
         rx_flag_q <= {RXN{1'b0}};
         tx_mask_q <= {TXN{1'b0}};
         rx_mask_q <= {RXN{1'b0}};
         sub_q <= `SCB_SUB_STD;
         loop_q <= 1'b0;
         median_q <= 1'b0;
         enable_d1_q <= 1'b0;
         prdata <= `SCB_WORD_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
         rx_sync_q <= 3'h7;
         med_q <= 3'h7;
         rx_clean_q <= 1'b1;
         tx_line <= 1'b1;
         eng_rx_bit <= 1'b1;
         eng_tx_word <= {DW{1'b0}};
         eng_tx_valid <= 1'b0;
         uart_active <= 1'b0;
         sub_mode <= `SCB_SUB_STD;
         frame_bits_m1 <= `SCB_WIDTH_RST;
         tx_msb_first <= 1'b0;
         rx_msb_first <= 1'b0;
         tx_run <= 1'b0;
         rx_run <= 1'b0;
         shift_clear_tx <= 1'b1;
         shift_clear_rx <= 1'b1;
         irq_tx <= 1'b0;
         irq_rx <= 1'b0;
      end else begin
         // ----------------------------------------------------------
         // register bus
         // ----------------------------------------------------------

         // no wait state: pready answers in the first access cycle
         pready <= psel & ~penable;
         if (psel & ~penable) begin
            prdata <= rdata;
            pslverr <= ~hit;
         end
         if (wr) begin
            case (paddr)
               `SCB_OFF_CTRL:      ctrl_q <= pwdata;
               `SCB_OFF_UART_CTRL: uctrl_q <= pwdata;
               `SCB_OFF_TX_CTRL:   txc_q <= pwdata;
               `SCB_OFF_RX_CTRL:   rxc_q <= pwdata;
               `SCB_OFF_TXQ_CTRL:  txq_q <= pwdata;
               `SCB_OFF_RXQ_CTRL:  rxq_q <= pwdata;
               `SCB_OFF_TX_MASK:   tx_mask_q <= pwdata[TXN-1:0];
               `SCB_OFF_RX_MASK:   rx_mask_q <= pwdata[RXN-1:0];
               default: ;
            endcase
         end

         // ----------------------------------------------------------
         // sticky flags and interrupt outputs
         // ----------------------------------------------------------

         // the event term is or-ed last, so a clear never hides it
         tx_flag_q <= (tx_flag_q & ~tx_w1c) | tx_ev;
         rx_flag_q <= (rx_flag_q & ~rx_w1c) | rx_ev;
         irq_tx <= |(tx_flag_q & tx_mask_q);
         irq_rx <= |(rx_flag_q & rx_mask_q);

         // ----------------------------------------------------------
         // configuration snapshot
         // ----------------------------------------------------------

         enable_d1_q <= blk_on;
         // live settings changed while enabled stay unseen until re-enable
         if (reinit) begin
            sub_q <= uctrl_q[`SCB_MODE_HI:`SCB_MODE_LO];
            loop_q <= uctrl_q[`SCB_LOOP_BIT];
            median_q <= rxc_q[`SCB_MEDIAN_BIT];
            frame_bits_m1 <= txc_q[`SCB_WIDTH_HI:0];
            tx_msb_first <= txc_q[`SCB_MSB_BIT];
            rx_msb_first <= rxc_q[`SCB_MSB_BIT];
         end

         // ----------------------------------------------------------
         // receive pin path
         // ----------------------------------------------------------

         // three-stage pin sync; accept once stages 2 and 3 agree
         // a one-cycle spike never reaches the engine for that reason
         rx_sync_q <= {rx_sync_q[1:0], rx_line};
         if (rx_sync_q[2] == rx_sync_q[1] && rx_changed)
            rx_clean_q <= rx_sync_q[2];
         med_q <= {med_q[1:0], rx_src};
         eng_rx_bit <= median_q ? med_out : rx_src;

         // ----------------------------------------------------------
         // engine side outputs
         // ----------------------------------------------------------

         // idle line is high, so a disabled transmitter looks like stop
         tx_line <= tx_en ? eng_tx_bit : 1'b1;
         eng_tx_word <= tx_empty ? {DW{1'b0}} :
                        txm[tx_rp_q[DEPTH_LOG-1:0]];
         eng_tx_valid <= tx_en & ~tx_empty & ~tx_frz & ~tx_clr;
         uart_active <= active;
         sub_mode <= sub_q;
         tx_run <= tx_en;
         rx_run <= rx_en;
         shift_clear_tx <= tx_clr;
         shift_clear_rx <= rx_clr;
      end
   end

endmodule

// [bench/scb_uart_chk.sv]
/* checker for the serial block's UART setup logic: bus timing,
   config hold while enabled, idle state while disabled.
   assumes it is bound onto the scb_uart_setup ports. */
module scb_uart_chk (
   input logic        ref_clk,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic        pready,
   input logic        pslverr,
   input logic [31:0] prdata,
   input logic        tx_line,
   input logic        tx_run,
   input logic        rx_run,
   input logic        uart_active,
   input logic [1:0]  sub_mode,
   input logic [3:0]  frame_bits_m1,
   input logic        shift_clear_tx,
   input logic        eng_tx_valid,
   input logic        irq_tx,
   input logic        irq_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_apb_answer: assert property ((psel && !penable) ##1 (psel && penable)
      |-> pready) else $error("no answer in first access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_zero: assert property (pready && pslverr && !pwrite
      |-> prdata == 32'h0) else $error("refused read not zero");
   chk_cfg_hold: assert property (
      uart_active && $past(uart_active, 2)
      |-> $stable(sub_mode) && $stable(frame_bits_m1))
      else $error("config moved while enabled");
   chk_tx_idle: assert property (!tx_run [*2] |-> tx_line)
      else $error("tx line low while disabled");
   chk_off_clear: assert property (
      !uart_active [*2] |-> shift_clear_tx && !eng_tx_valid)
      else $error("queue kept while disabled");
   chk_off_idle: assert property (
      !uart_active [*2] |-> !tx_run && !rx_run)
      else $error("direction runs while block off");
   chk_irq_start: assert property ($past(rst) |-> !irq_tx && !irq_rx)
      else $error("interrupt right after reset");
endmodule

// [bench/scb_far_end.sv]
/* remote transmitter on the serial input: holds a level, can
   throw a one-cycle glitch. assumes the bench clock. */
module scb_far_end (
   input  logic ref_clk,
   input  logic lvl,
   input  logic glitch,
   output logic rx_line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rx_line = 1'h1;
   always @(posedge ref_clk) begin
      rx_line <= glitch ? !lvl : lvl;
   end
endmodule

// [bench/tb_scb_uart_setup.sv]
/* self-checking bench for scb_uart_setup over APB.
   assumes 250 MHz ref_clk and the hand-over register map. */
module tb_scb_uart_setup;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, rx_line, tx_line, eng_tx_bit = 0;
   logic [15:0] eng_tx_word, eng_rx_word = 16'h0, r;
   logic        eng_tx_valid, eng_tx_pop = 0, eng_rx_push = 0, eng_rx_bit;
   logic        uart_active, tx_msb_first, rx_msb_first, tx_run, rx_run;
   logic        shift_clear_tx, shift_clear_rx, irq_tx, irq_rx;
   logic        lvl = 1, glitch = 0, msb, err;
   logic [1:0]  sub_mode;
   logic [3:0]  frame_bits_m1, w;
   logic [6:0]  evs = 7'h00;
   logic [11:0] ma;
   int          errors = 0, samples_checked = 0, cyc = 0, k, b;

   always #2 ref_clk = ~ref_clk;

   scb_uart_setup scb_uart_setup_inst (.ref_clk(ref_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_line(rx_line), .tx_line(tx_line), .eng_tx_bit(eng_tx_bit),
      .eng_tx_word(eng_tx_word), .eng_tx_valid(eng_tx_valid),
      .eng_tx_pop(eng_tx_pop), .eng_rx_word(eng_rx_word),
      .eng_rx_push(eng_rx_push), .eng_rx_bit(eng_rx_bit),
      .uart_active(uart_active), .sub_mode(sub_mode),
      .frame_bits_m1(frame_bits_m1), .tx_msb_first(tx_msb_first),
      .rx_msb_first(rx_msb_first), .tx_run(tx_run), .rx_run(rx_run),
      .shift_clear_tx(shift_clear_tx), .shift_clear_rx(shift_clear_rx),
      .ev_nack(evs[0]), .ev_tx_done(evs[1]), .ev_arb_lost(evs[2]),
      .ev_frame_err(evs[3]), .ev_parity_err(evs[4]), .ev_lin_baud(evs[5]),
      .ev_lin_break(evs[6]), .irq_tx(irq_tx), .irq_rx(irq_rx));
   scb_far_end scb_far_end_inst (.ref_clk(ref_clk), .lvl(lvl),
      .glitch(glitch), .rx_line(rx_line));

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // starts one edge late so release and next setup never collide
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) begin
         errors++;
         summarize();
      end
   endtask
   task cfg(input logic [1:0] m, input logic lp);
      apb(1, 12'h000, 32'h0);
      apb(1, 12'h040, {6'h0, m, 7'h0, lp, 16'h0});
      apb(1, 12'h200, {1'h1, 22'h0, msb, 4'h0, w});
      apb(1, 12'h300, {1'h1, 21'h0, m == 2'h2, !msb, 4'h0, w});
      apb(1, 12'h000, 32'h8200_0000);
      tick(4);
   endtask
   task push_rx;
      @(posedge ref_clk);
      eng_rx_word <= r;
      eng_rx_push <= 1;
      @(posedge ref_clk);
      eng_rx_push <= 0;
      tick(2);
   endtask
   task summarize;
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         summarize();
      end
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      void'($urandom(93));
      tick(20);
      chk("width_rst", 4'h7, frame_bits_m1);
      rst <= 0;
      apb(0, 12'hFFC, 32'h0);
      chk("slverr", 1, err);
      chk("rdata", 0, q);
      apb(1, 12'h000, 32'h8100_0000);
      tick(4);
      chk("spi_active", 0, uart_active);
      for (k = 0; k < 3; k++) begin
         w = 4'h3 + 4'($urandom_range(12));
         msb = $urandom;
         cfg(k[1:0], 0);
         chk("active", 1, uart_active);
         chk("sub_mode", k, sub_mode);
         chk("width", w, frame_bits_m1);
         chk("tx_msb", msb, tx_msb_first);
         chk("rx_msb", !msb, rx_msb_first);
         chk("runs", 2'h3, {tx_run, rx_run});
         apb(1, 12'h040, 32'h0300_0000);
         tick(4);
         chk("held_mode", k, sub_mode);
      end
      tick(8);
      @(posedge ref_clk) glitch <= 1;
      @(posedge ref_clk) glitch <= 0;
      for (k = 0; k < 10; k++) begin
         tick(1);
         chk("median", 1, eng_rx_bit);
      end
      lvl <= 0;
      tick(10);
      chk("rx_low", 0, eng_rx_bit);
      cfg(2'h2, 1);
      eng_tx_bit <= 1;
      tick(10);
      chk("loop", 1, eng_rx_bit);
      apb(1, 12'h404, 32'h4);
      tick(4);
      chk("irq_empty", 1, irq_tx);
      apb(1, 12'h404, 32'h0);
      tick(3);
      chk("irq_masked", 0, irq_tx);
      for (k = 1; k < 7; k++) begin
         b = (k < 3) ? k + 5 : k + 2;
         ma = (k < 3) ? 12'h404 : 12'h40C;
         apb(1, ma, 32'h1 << b);
         tick(3);
         chk("irq_before", 0, k < 3 ? irq_tx : irq_rx);
         @(posedge ref_clk) evs <= 7'h01 << k;
         @(posedge ref_clk) evs <= 7'h00;
         tick(4);
         chk("irq_event", 1, k < 3 ? irq_tx : irq_rx);
         apb(1, ma - 12'h004, 32'h1 << b);
         tick(3);
         chk("irq_cleared", 0, k < 3 ? irq_tx : irq_rx);
         apb(1, ma, 32'h0);
      end
      r = $urandom;
      apb(1, 12'h500, {16'h0, r});
      tick(2);
      chk("tx_head", {1'h1, r}, {eng_tx_valid, eng_tx_word});
      apb(1, 12'h204, 32'h3);
      apb(1, 12'h404, 32'h1);
      tick(3);
      chk("irq_below", 1, irq_tx);
      repeat (2) apb(1, 12'h500, {16'h0, r});
      apb(1, 12'h400, 32'h1);
      tick(3);
      chk("irq_at_level", 0, irq_tx);
      apb(1, 12'h204, 32'h0001_0003);
      tick(3);
      chk("tx_clear", 2'h1, {eng_tx_valid, shift_clear_tx});
      apb(1, 12'h204, 32'h3);
      apb(1, 12'h404, 32'h0);
      push_rx();
      apb(0, 12'h504, 32'h0);
      chk("rx_word", {16'h0, r}, q);
      apb(1, 12'h304, 32'h0002_0000);
      push_rx();
      apb(1, 12'h304, 32'h0);
      apb(0, 12'h504, 32'h0);
      chk("frozen", 0, q);
      push_rx();
      apb(1, 12'h000, 32'h0);
      apb(1, 12'h000, 32'h8200_0000);
      tick(4);
      apb(0, 12'h504, 32'h0);
      chk("reinit", 0, q);
      summarize();
   end
endmodule

bind scb_uart_setup scb_uart_chk scb_uart_chk_inst (.ref_clk(ref_clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .prdata(prdata), .tx_line(tx_line),
   .tx_run(tx_run), .rx_run(rx_run), .uart_active(uart_active),
   .sub_mode(sub_mode), .frame_bits_m1(frame_bits_m1),
   .shift_clear_tx(shift_clear_tx), .eng_tx_valid(eng_tx_valid),
   .irq_tx(irq_tx), .irq_rx(irq_rx));
